// [shared/dac_latch_pkg.sv]
// constants and types for the converter input latch front end
package dac_latch_pkg;
  localparam int unsigned DATA_W      = 10;
  localparam int unsigned MSB_POS     = 9;
  localparam logic [9:0]  CODE_RESET  = 10'h000;
  localparam logic [9:0]  CODE_ONES   = 10'h3ff;
  localparam logic [9:0]  MSB_MASK    = 10'h200;
  localparam int unsigned CLK_HZ      = 50000000;
  localparam int unsigned SLEEP_DOWN_US = 5;
  localparam int unsigned SLEEP_UP_MS   = 3;
  localparam int unsigned SLEEP_DOWN_CYC = (CLK_HZ / 1000000) * SLEEP_DOWN_US;
  localparam int unsigned SLEEP_UP_CYC   = (CLK_HZ / 1000) * SLEEP_UP_MS;
  localparam logic [17:0] CNT_ZERO    = 18'h00000;
  localparam logic [17:0] CNT_ONE     = 18'h00001;

  typedef enum logic [1:0] {
    PWR_ACTIVE   = 2'b00,
    PWR_SLEEPING = 2'b01,
    PWR_DOWN     = 2'b11,
    PWR_WAKING   = 2'b10
  } pwr_state_t;

  // format select: low is straight binary, high is twos complement
  typedef enum logic {
    FMT_BINARY = 1'b0,
    FMT_TWOS   = 1'b1
  } fmt_t;

  // offset binary conversion of a twos complement word
  function automatic logic [9:0] decode_word(input logic [9:0] w, input logic twos);
    decode_word = twos ? (w ^ MSB_MASK) : w;
  endfunction
endpackage

// [src/dac_code_decode.sv]
// input register and code decoder of the converter
`timescale 1ns/1ps
module dac_code_decode
  import dac_latch_pkg::*;
(
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst,
  // parallel word and format
  input  wire logic [DATA_W-1:0] data_in,
  input  wire logic              fmt_sel,
  // decoded code toward the steering array
  output logic      [DATA_W-1:0] code
);
  logic [DATA_W-1:0] word;
  logic              word_fmt;
  logic [DATA_W-1:0] next_word;
  logic              next_word_fmt;
  logic [DATA_W-1:0] next_code;

  // capture word and format together so they stay paired
  always_comb begin
    next_word     = data_in;
    next_word_fmt = fmt_sel;
    next_code     = decode_word(word, word_fmt == FMT_TWOS);
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      word     <= CODE_RESET;
      word_fmt <= FMT_BINARY;
      code     <= CODE_RESET;
    end else begin
      word     <= next_word;
      word_fmt <= next_word_fmt;
      code     <= next_code;
    end
  end
endmodule

// [src/dac_input_latch_control.sv]
// digital front end of a 10-bit current-output converter
// How it works
// - the data word is captured on each rising clock edge only.
// - the word is ten bits, bit 9 most significant and bit 0 least.
// - the format input selects straight binary or twos complement decoding.
// - a low format input means format zero, straight binary; nothing pulls it low when undriven.
// - the true output is full scale when every decoded bit is one.
// - the complementary output is the inverse, full scale at all zeros.
// - a high sleep input blanks the outputs at once, without the clock; powered_down follows after the SLEEP_DOWN_CYC count.
`timescale 1ns/1ps
module dac_input_latch_control
  import dac_latch_pkg::*;
(
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst,
  // parallel data from the driving logic
  input  wire logic [DATA_W-1:0] data_in,
  // format select and sleep, neither pulled low when undriven
  input  wire logic              fmt_sel,
  input  wire logic              sleep,
  // digital drive of the current-steering array
  output logic      [DATA_W-1:0] true_current_output,
  output logic      [DATA_W-1:0] complementary_current_output,
  // power status
  output logic                   powered_down,
  output logic                   output_valid
);
  logic [DATA_W-1:0] code;
  pwr_state_t        state;
  pwr_state_t        next_state;
  logic [17:0]       cnt;
  logic [17:0]       next_cnt;

  dac_code_decode u_decode (
    .clk_sys (clk_sys),
    .rst     (rst),
    .data_in (data_in),
    .fmt_sel (fmt_sel),
    .code    (code)
  );

  // sleep forces outputs off with no clock
  always_comb begin
    if (sleep) begin
      true_current_output          = CODE_RESET;
      complementary_current_output = CODE_RESET;
    end else begin
      true_current_output          = code;
      complementary_current_output = code ^ CODE_ONES;
    end
  end

  // power sequencing; status only, the driver still owns the waits
  always_comb begin
    next_state = state;
    next_cnt   = (cnt == CNT_ZERO) ? CNT_ZERO : cnt - CNT_ONE;
    unique case (state)
      PWR_ACTIVE: begin
        if (sleep) begin
          next_state = PWR_SLEEPING;
          next_cnt   = 18'(SLEEP_DOWN_CYC - 1);
        end
      end
      PWR_SLEEPING: begin
        if (!sleep) begin
          next_state = PWR_WAKING;
          next_cnt   = 18'(SLEEP_UP_CYC - 1);
        end else if (cnt == CNT_ZERO) begin
          next_state = PWR_DOWN;
        end
      end
      PWR_DOWN: begin
        if (!sleep) begin
          next_state = PWR_WAKING;
          next_cnt   = 18'(SLEEP_UP_CYC - 1);
        end
      end
      PWR_WAKING: begin
        if (sleep) begin
          next_state = PWR_SLEEPING;
          next_cnt   = 18'(SLEEP_DOWN_CYC - 1);
        end else if (cnt == CNT_ZERO) begin
          next_state = PWR_ACTIVE;
        end
      end
    endcase
  end

  // register power state
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state <= PWR_ACTIVE;
      cnt   <= CNT_ZERO;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
    end
  end

  // status from state; sleep drops valid at once
  always_comb begin
    powered_down = (state == PWR_DOWN);
    output_valid = (state == PWR_ACTIVE) && !sleep;
  end
endmodule

// [dv/dac_latch_chk.sv]
// port checker of the converter front end
`timescale 1ns/1ps
module dac_latch_chk
  import dac_latch_pkg::*;
(
  // clock, reset and inputs
  input wire logic              clk_sys,
  input wire logic              rst,
  input wire logic [DATA_W-1:0] data_in,
  input wire logic              fmt_sel,
  input wire logic              sleep,
  // outputs
  input wire logic [DATA_W-1:0] true_current_output,
  input wire logic [DATA_W-1:0] complementary_current_output,
  input wire logic              powered_down,
  input wire logic              output_valid
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire logic [DATA_W-1:0] tc = true_current_output;
  wire logic [DATA_W-1:0] cc = complementary_current_output;
  // capture, decode and apply need three awake edges
  sequence s_quiet;
    !sleep ##1 !sleep ##1 !sleep;
  endsequence
  chk_decode_path: assert property (s_quiet |-> tc == ($past(data_in, 2) ^
    ($past(fmt_sel, 2) ? MSB_MASK : CODE_RESET))) else $error("decoded code wrong");
  chk_binary_plain: assert property (s_quiet ##0 !$past(fmt_sel, 2)
    |-> tc == $past(data_in, 2)) else $error("binary code altered");
  chk_full_scale: assert property (s_quiet ##0 ($past(data_in, 2) == CODE_ONES
    && !$past(fmt_sel, 2)) |-> tc == CODE_ONES) else $error("no full scale");
  chk_comp_inverse: assert property (!sleep |-> cc == ~tc) else $error("not inverse");
  chk_sleep_blank: assert property (sleep |-> (tc | cc) == CODE_RESET) else $error("awake");
  chk_valid_low: assert property (sleep |-> !output_valid) else $error("valid in sleep");
  chk_down_wait: assert property ($rose(powered_down) |-> $past(sleep, 200))
    else $error("down too soon");
  chk_wake_gap: assert property ($fell(sleep) |-> !output_valid [*8])
    else $error("valid too soon");
endmodule
bind dac_input_latch_control dac_latch_chk u_chk (.clk_sys, .rst, .data_in, .fmt_sel, .sleep,
  .true_current_output, .complementary_current_output, .powered_down, .output_valid);

// [dv/dac_data_source.sv]
// model of the logic that drives the parallel word
`timescale 1ns/1ps
module dac_data_source
  import dac_latch_pkg::*;
(
  // clock and requested word
  input  wire logic              clk_sys,
  input  wire logic [DATA_W-1:0] word,
  input  wire logic              fmt,
  // pins toward the converter
  output logic      [DATA_W-1:0] data_in = 10'h000,
  output logic                   fmt_sel = 1'b0
);
  // one word a clock
  // falling-edge launch keeps setup and hold clear of the capture edge
  always @(negedge clk_sys) begin
    data_in <= word;
    fmt_sel <= fmt;
  end
endmodule

// [dv/dac_input_latch_control_bench.sv]
// self-checking bench of the converter front end
`timescale 1ns/1ps
module dac_input_latch_control_bench;
  import dac_latch_pkg::*;
  logic       clk_sys = 0, rst = 1, sleep = 0, fmt = 0;
  logic [9:0] word = 10'h000;
  wire  [9:0] d, tc, cc;
  wire        fs, pd, ov;
  int         n_mismatch = 0, total_checks = 0;
  initial forever #10 clk_sys = ~clk_sys;
  dac_data_source u_src (.clk_sys, .word, .fmt, .data_in(d), .fmt_sel(fs));
  dac_input_latch_control u_dut (.clk_sys, .rst, .data_in(d), .fmt_sel(fs), .sleep,
    .true_current_output(tc), .complementary_current_output(cc), .powered_down(pd),
    .output_valid(ov));
  task automatic check(logic [9:0] seen, logic [9:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // request after a rising edge, judge three rising edges on
  task automatic put_word(logic [9:0] w, logic f, logic [9:0] e);
    @(posedge clk_sys);
    word <= w;
    fmt <= f;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    check(tc, e);
    check(cc, ~e);
  endtask
  // blanking at once, bounded wait for power-down, no early valid
  task automatic t_sleep;
    int n;
    n = 0;
    @(negedge clk_sys);
    sleep = 1;
    #1;
    check(tc | cc, 10'h000);
    check({9'h000, ov}, 10'h000);
    while (pd !== 1'b1 && n < 300) begin
      @(negedge clk_sys);
      n++;
    end
    if (n == 300) begin
      n_mismatch++;
      return;
    end
    check({9'h000, n > 200}, 10'h001);
    sleep = 0;
    repeat (20) @(negedge clk_sys);
    check({9'h000, ov}, 10'h000);
  endtask
  initial begin
    repeat (8) @(negedge clk_sys);
    rst = 0;
    check(cc, CODE_ONES);
    check({9'h000, ov}, 10'h001);
    check({9'h000, pd}, 10'h000);
    put_word(10'h3ff, 0, 10'h3ff);
    put_word(10'h001, 0, 10'h001);
    put_word(10'h200, 0, 10'h200);
    put_word(10'h000, 1, 10'h200);
    put_word(10'h1ff, 1, 10'h3ff);
    put_word(10'h3ff, 1, 10'h1ff);
    t_sleep();
    give_verdict();
  end
endmodule
